// ===== hdl/sgp_pkg.sv
// sgp_pkg: constants for the switch global policy control block
// assumes a 100 MHz core clock and a byte-wide management register port
package sgp_pkg;
   // register offsets on the management port
   localparam logic [7:0] SGP_CTL1_ADDR = 8'h03;
   localparam logic [7:0] SGP_CTL2_ADDR = 8'h04;
   // control one field positions
   localparam int SGP_C1_TX_PAUSE = 5;
   localparam int SGP_C1_RX_PAUSE = 4;
   localparam int SGP_C1_LEN_CHK = 3;
   localparam int SGP_C1_AGE_EN = 2;
   localparam int SGP_C1_FAST_AGE = 1;
   localparam int SGP_C1_AGGR_BO = 0;
   // control two field positions
   localparam int SGP_C2_VLAN_STRICT = 7;
   localparam int SGP_C2_STORM_BC_ONLY = 6;
   localparam int SGP_C2_BP_CARRIER = 5;
   localparam int SGP_C2_FAIR = 4;
   localparam int SGP_C2_KEEP_EXC = 3;
   localparam int SGP_C2_HUGE = 2;
   localparam int SGP_C2_LEGAL_CHK = 1;
   // writable bits and values after reset (upper bits of control one read zero)
   localparam logic [7:0] SGP_CTL1_MASK = 8'h3F;
   localparam logic [7:0] SGP_CTL1_RESET = 8'h34;
   localparam logic [7:0] SGP_CTL2_MASK = 8'hFF;
   localparam logic [7:0] SGP_CTL2_RESET = 8'hF0;
   // frame size limits in bytes
   localparam logic [10:0] SGP_LEN_HUGE = 11'h77C; // 1916
   localparam logic [10:0] SGP_LEN_PLAIN = 11'h600; // 1536
   localparam logic [10:0] SGP_LEN_TAGGED = 11'h5F2; // 1522
   localparam logic [10:0] SGP_LEN_UNTAGGED = 11'h5EE; // 1518
   localparam logic [15:0] SGP_LENTYPE_LIMIT = 16'h05DC; // 1500
   localparam logic [4:0] SGP_EXC_COLL = 5'h10; // 16 collisions
   localparam int SGP_DA_GROUP_BIT = 40;
   // aging timing
   localparam int SGP_CLK_PERIOD_NS = 10;
   localparam int SGP_FAST_AGE_US = 800;
   localparam int SGP_FAST_AGE_CYCLES = SGP_FAST_AGE_US * 1000 / SGP_CLK_PERIOD_NS;
   localparam int SGP_NORM_AGE_CYCLES = 30000000;
endpackage

// ===== hdl/sgp_age_if.sv
// sgp_age_if: aging control between the policy bank and its age timer
// assumes both ends share CLK
interface sgp_age_if;
   logic enable;
   logic fast;
   logic tick;
   modport ctl (output enable, output fast, input tick);
   modport tmr (input enable, input fast, output tick);
endinterface

// ===== hdl/sgp_age_timer.sv
// sgp_age_timer: periodic aging pulse, normal or fast period
// assumes CLK at 100 MHz and synchronous enable inputs
module sgp_age_timer
   import sgp_pkg::*;
#(
   parameter int FAST_CYCLES = SGP_FAST_AGE_CYCLES,
   parameter int NORM_CYCLES = SGP_NORM_AGE_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   sgp_age_if.tmr age
);
   logic [31:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic [31:0] limit;

   // period select; counter restarts when disabled or after each tick, not on a change of speed
   always_comb begin
      limit = age.fast ? 32'(FAST_CYCLES - 1) : 32'(NORM_CYCLES - 1);
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (!age.enable) begin
         cnt_d = 32'h0;
      end else if (cnt_q >= limit) begin
         cnt_d = 32'h0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 32'h1;
      end
   end

   // counter registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign age.tick = tick_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_age_stops_off: assert property (!age.enable ##1 !age.enable |=> !tick_q)
      else $error("aging tick while aging disabled");
   a_fast_tick_gap: assert property (tick_q && age.fast && age.enable
         && $stable(age.fast) |=> !tick_q [*8])
      else $error("fast aging tick repeated back to back");
endmodule // sgp_age_timer

// ===== hdl/sgp_policy_ctl.sv
// sgp_policy_ctl: global policy control registers of a three-port switch
// assumes a byte-wide register port synchronous to CLK; frame check inputs
// come from the receive path one frame per valid pulse
module sgp_policy_ctl
   import sgp_pkg::*;
#(
   parameter int FAST_AGE_CYCLES = SGP_FAST_AGE_CYCLES,
   parameter int NORM_AGE_CYCLES = SGP_NORM_AGE_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic FRM_VALID,
   input wire logic [10:0] FRM_LEN,
   input wire logic FRM_TAGGED,
   input wire logic [15:0] FRM_LENTYPE,
   input wire logic [10:0] FRM_DATA_LEN,
   input wire logic [47:0] FRM_DA,
   input wire logic FRM_PAUSE,
   input wire logic [4:0] FRM_COLL_CNT,
   output logic FRM_DONE,
   output logic FRM_DROP,
   output logic FRM_STORM,
   output logic FRM_PAUSE_ACT,
   output logic [10:0] MAX_LEN,
   output logic TX_PAUSE_EN,
   output logic AGGR_BACKOFF,
   output logic VLAN_STRICT,
   output logic BP_CARRIER,
   output logic FAIR_MODE,
   output logic AGE_TICK
);
   logic [7:0] ctl1_q, ctl1_d;
   logic [7:0] ctl2_q, ctl2_d;
   logic [7:0] rdata_q, rdata_d;
   logic done_q, done_d;
   logic drop_q, drop_d;
   logic storm_q, storm_d;
   logic pause_q, pause_d;
   logic [10:0] max_q, max_d;
   logic len_bad, size_bad, coll_bad;

   sgp_age_if age ();

   // register writes and readback
   always_comb begin
      ctl1_d = ctl1_q;
      ctl2_d = ctl2_q;
      rdata_d = rdata_q;
      if (REG_WR && REG_ADDR == SGP_CTL1_ADDR) begin
         ctl1_d = REG_WDATA & SGP_CTL1_MASK;
      end
      if (REG_WR && REG_ADDR == SGP_CTL2_ADDR) begin
         ctl2_d = REG_WDATA & SGP_CTL2_MASK;
      end
      if (REG_RD) begin
         unique case (REG_ADDR)
            SGP_CTL1_ADDR: rdata_d = ctl1_q;
            SGP_CTL2_ADDR: rdata_d = ctl2_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // register state, defaults on reset
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctl1_q <= SGP_CTL1_RESET;
         ctl2_q <= SGP_CTL2_RESET;
         rdata_q <= 8'h00;
      end else begin
         ctl1_q <= ctl1_d;
         ctl2_q <= ctl2_d;
         rdata_q <= rdata_d;
      end
   end

   // size limit selection: huge overrides legal check
   always_comb begin
      if (ctl2_q[SGP_C2_HUGE]) begin
         max_d = SGP_LEN_HUGE;
      end else if (ctl2_q[SGP_C2_LEGAL_CHK]) begin
         max_d = FRM_TAGGED ? SGP_LEN_TAGGED : SGP_LEN_UNTAGGED;
      end else begin
         max_d = SGP_LEN_PLAIN;
      end
   end

   // per-frame drop, storm and pause decisions
   always_comb begin
      len_bad = ctl1_q[SGP_C1_LEN_CHK] && (FRM_LENTYPE < SGP_LENTYPE_LIMIT)
         && (FRM_LENTYPE[10:0] != FRM_DATA_LEN || FRM_LENTYPE[15:11] != 5'h00);
      size_bad = FRM_LEN > max_d;
      coll_bad = !ctl2_q[SGP_C2_KEEP_EXC] && (FRM_COLL_CNT >= SGP_EXC_COLL);
      done_d = FRM_VALID;
      drop_d = FRM_VALID && (len_bad || size_bad || coll_bad);
      storm_d = FRM_VALID && ((&FRM_DA)
         || (!ctl2_q[SGP_C2_STORM_BC_ONLY] && FRM_DA[SGP_DA_GROUP_BIT]));
      pause_d = FRM_VALID && FRM_PAUSE && ctl1_q[SGP_C1_RX_PAUSE];
   end

   // decision registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         done_q <= 1'b0;
         drop_q <= 1'b0;
         storm_q <= 1'b0;
         pause_q <= 1'b0;
         max_q <= SGP_LEN_PLAIN;
      end else begin
         done_q <= done_d;
         drop_q <= drop_d;
         storm_q <= storm_d;
         pause_q <= pause_d;
         max_q <= max_d;
      end
   end

   // aging control to the timer
   assign age.enable = ctl1_q[SGP_C1_AGE_EN];
   assign age.fast = ctl1_q[SGP_C1_FAST_AGE];

   sgp_age_timer #(
      .FAST_CYCLES(FAST_AGE_CYCLES),
      .NORM_CYCLES(NORM_AGE_CYCLES)
   ) u_age (
      .CLK(CLK),
      .RST_N(RST_N),
      .age(age)
   );

   // outputs straight from flip-flops
   assign REG_RDATA = rdata_q;
   assign FRM_DONE = done_q;
   assign FRM_DROP = drop_q;
   assign FRM_STORM = storm_q;
   assign FRM_PAUSE_ACT = pause_q;
   assign MAX_LEN = max_q;
   assign AGE_TICK = age.tick;
   assign TX_PAUSE_EN = ctl1_q[SGP_C1_TX_PAUSE];
   assign AGGR_BACKOFF = ctl1_q[SGP_C1_AGGR_BO];
   assign VLAN_STRICT = ctl2_q[SGP_C2_VLAN_STRICT];
   assign BP_CARRIER = ctl2_q[SGP_C2_BP_CARRIER];
   assign FAIR_MODE = ctl2_q[SGP_C2_FAIR];

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_write_c2;
      REG_WR && REG_ADDR == SGP_CTL2_ADDR;
   endsequence
   sequence s_read_c2;
      REG_RD && REG_ADDR == SGP_CTL2_ADDR && !REG_WR;
   endsequence

   a_reg_readback: assert property (s_write_c2 ##1 s_read_c2
         |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("control two readback differs from write");
   a_pause_ignored: assert property (!ctl1_q[SGP_C1_RX_PAUSE] |=> !FRM_PAUSE_ACT)
      else $error("pause acted on while receive pause disabled");
   a_len_mismatch_drop: assert property (FRM_VALID && ctl1_q[SGP_C1_LEN_CHK]
         && FRM_LENTYPE < SGP_LENTYPE_LIMIT && FRM_LENTYPE[10:0] != FRM_DATA_LEN
         |=> FRM_DROP)
      else $error("length mismatch not dropped");
   a_huge_limit: assert property (ctl2_q[SGP_C2_HUGE] |=> MAX_LEN == SGP_LEN_HUGE)
      else $error("huge limit not selected");
   a_legal_tagged: assert property (!ctl2_q[SGP_C2_HUGE] && ctl2_q[SGP_C2_LEGAL_CHK]
         && FRM_TAGGED |=> MAX_LEN == SGP_LEN_TAGGED)
      else $error("tagged legal limit wrong");
   a_storm_scope: assert property (FRM_VALID && ctl2_q[SGP_C2_STORM_BC_ONLY]
         && !(&FRM_DA) |=> !FRM_STORM)
      else $error("multicast counted as storm in broadcast-only mode");
   a_exc_coll_drop: assert property (FRM_VALID && !ctl2_q[SGP_C2_KEEP_EXC]
         && FRM_COLL_CNT >= SGP_EXC_COLL |=> FRM_DROP)
      else $error("excessive collision frame kept");
   a_reset_defaults: assert property ($rose(RST_N) |-> ctl2_q == SGP_CTL2_RESET
         || $past(REG_WR))
      else $error("control two not at default after reset");

   // control one write and read strobes
   sequence s_write_c1;
      REG_WR && REG_ADDR == SGP_CTL1_ADDR;
   endsequence
   sequence s_read_c1;
      REG_RD && REG_ADDR == SGP_CTL1_ADDR && !REG_WR;
   endsequence

   // level outputs follow the written bit one cycle after the write
   a_tx_pause_level: assert property (s_write_c1
         |=> TX_PAUSE_EN == $past(REG_WDATA[SGP_C1_TX_PAUSE]))
      else $error("transmit pause enable does not follow write");
   a_backoff_level: assert property (s_write_c1
         |=> AGGR_BACKOFF == $past(REG_WDATA[SGP_C1_AGGR_BO]))
      else $error("aggressive back-off does not follow write");
   a_vlan_level: assert property (s_write_c2
         |=> VLAN_STRICT == $past(REG_WDATA[SGP_C2_VLAN_STRICT]))
      else $error("vlan strict level does not follow write");
   a_bp_level: assert property (s_write_c2
         |=> BP_CARRIER == $past(REG_WDATA[SGP_C2_BP_CARRIER]))
      else $error("back-pressure style does not follow write");
   a_fair_level: assert property (s_write_c2
         |=> FAIR_MODE == $past(REG_WDATA[SGP_C2_FAIR]))
      else $error("fair mode level does not follow write");
   a_upper_zero: assert property (s_read_c1 |=> REG_RDATA[7:6] == 2'b00)
      else $error("unstored control one bits read nonzero");

   // verdicts only for a presented frame, limits per mode
   a_verdict_idle: assert property (!FRM_VALID
         |=> !FRM_DONE && !FRM_DROP && !FRM_STORM && !FRM_PAUSE_ACT)
      else $error("frame verdict without a frame");
   a_plain_limit: assert property (!ctl2_q[SGP_C2_HUGE] && !ctl2_q[SGP_C2_LEGAL_CHK]
         |=> MAX_LEN == SGP_LEN_PLAIN)
      else $error("plain size limit wrong");
   a_legal_untagged: assert property (!ctl2_q[SGP_C2_HUGE] && ctl2_q[SGP_C2_LEGAL_CHK]
         && !FRM_TAGGED |=> MAX_LEN == SGP_LEN_UNTAGGED)
      else $error("untagged legal limit wrong");
   a_huge_accept: assert property (FRM_VALID && ctl2_q[SGP_C2_HUGE]
         && !ctl1_q[SGP_C1_LEN_CHK] && FRM_LEN <= SGP_LEN_HUGE
         && FRM_COLL_CNT < SGP_EXC_COLL |=> !FRM_DROP)
      else $error("frame within huge limit dropped");
   a_tick_needs_enable: assert property (AGE_TICK |-> $past(ctl1_q[SGP_C1_AGE_EN]))
      else $error("aging tick while aging disabled");
endmodule // sgp_policy_ctl

// ===== verification/tb_switch_global_policy_control.sv
// tb_switch_global_policy_control: self-checking bench for sgp_policy_ctl
// assumes sgp_pkg compiled first; aging periods shortened by parameter
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_switch_global_policy_control
   import sgp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0, RST_N, REG_WR, REG_RD, FRM_VALID, FRM_TAGGED, FRM_PAUSE;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, c1_m, c2_m;
   logic [10:0] FRM_LEN, FRM_DATA_LEN, MAX_LEN;
   logic [15:0] FRM_LENTYPE;
   logic [47:0] FRM_DA;
   logic [4:0] FRM_COLL_CNT;
   logic FRM_DONE, FRM_DROP, FRM_STORM, FRM_PAUSE_ACT, TX_PAUSE_EN, AGGR_BACKOFF;
   logic VLAN_STRICT, BP_CARRIER, FAIR_MODE, AGE_TICK;
   logic [31:0] seed = 32'h0000FDB7;
   logic [31:0] r;
   logic [10:0] bnd [4] = '{11'h5EE, 11'h5F2, 11'h600, 11'h77C};
   int fail_count = 0, checks = 0, ticks;
   // free-running core clock, 10 ns period
   always #5 CLK = ~CLK;
   sgp_policy_ctl #(.FAST_AGE_CYCLES(16), .NORM_AGE_CYCLES(40)) i_dut (
      .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
      .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .FRM_VALID(FRM_VALID), .FRM_LEN(FRM_LEN), .FRM_TAGGED(FRM_TAGGED),
      .FRM_LENTYPE(FRM_LENTYPE), .FRM_DATA_LEN(FRM_DATA_LEN), .FRM_DA(FRM_DA),
      .FRM_PAUSE(FRM_PAUSE), .FRM_COLL_CNT(FRM_COLL_CNT), .FRM_DONE(FRM_DONE),
      .FRM_DROP(FRM_DROP), .FRM_STORM(FRM_STORM), .FRM_PAUSE_ACT(FRM_PAUSE_ACT),
      .MAX_LEN(MAX_LEN), .TX_PAUSE_EN(TX_PAUSE_EN), .AGGR_BACKOFF(AGGR_BACKOFF),
      .VLAN_STRICT(VLAN_STRICT), .BP_CARRIER(BP_CARRIER), .FAIR_MODE(FAIR_MODE),
      .AGE_TICK(AGE_TICK)
   );
   // xorshift source, fixed seed
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected size limit for the modelled settings
   function automatic logic [10:0] lim(logic t);
      return c2_m[2] ? 11'h77C : (c2_m[1] ? (t ? 11'h5F2 : 11'h5EE) : 11'h600);
   endfunction
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge CLK); #1;
      REG_ADDR = a; REG_WDATA = d; REG_WR = 1'b1;
      @(posedge CLK); #1;
      REG_WR = 1'b0;
      if (a == 8'h03) c1_m = d & 8'h3F;
      if (a == 8'h04) c2_m = d;
   endtask
   task automatic rd_chk(logic [7:0] a, logic [7:0] e);
      @(posedge CLK); #1;
      REG_ADDR = a; REG_RD = 1'b1;
      @(posedge CLK); #1;
      REG_RD = 1'b0;
      `CHK("reg_rdata", e, REG_RDATA)
   endtask
   // write, then read back at the very next edge
   task automatic wr_rd(logic [7:0] a, logic [7:0] d);
      wr(a, d);
      REG_RD = 1'b1;
      @(posedge CLK); #1;
      REG_RD = 1'b0;
      `CHK("reg_rdata_b2b", (a == 8'h03) ? c1_m : c2_m, REG_RDATA)
   endtask
   task automatic levels();
      `CHK("tx_pause_en", c1_m[5], TX_PAUSE_EN)
      `CHK("aggr_backoff", c1_m[0], AGGR_BACKOFF)
      `CHK("vlan_strict", c2_m[7], VLAN_STRICT)
      `CHK("bp_carrier", c2_m[5], BP_CARRIER)
      `CHK("fair_mode", c2_m[4], FAIR_MODE)
   endtask
   // one frame descriptor, verdicts checked one cycle later
   task automatic frame(logic t, logic [10:0] ln, logic [15:0] lt, logic [10:0] dl,
                        logic [47:0] da, logic p, logic [4:0] cc);
      logic ed;
      @(posedge CLK); #1;
      FRM_VALID = 1'b1; FRM_TAGGED = t; FRM_LEN = ln; FRM_LENTYPE = lt;
      FRM_DATA_LEN = dl; FRM_DA = da; FRM_PAUSE = p; FRM_COLL_CNT = cc;
      @(posedge CLK); #1;
      FRM_VALID = 1'b0;
      ed = (c1_m[3] && lt < 16'h05DC && lt != {5'h00, dl}) || ln > lim(t);
      ed = ed || (cc >= 5'h10 && !c2_m[3]);
      `CHK("frm_done", 1'b1, FRM_DONE)
      `CHK("frm_drop", ed, FRM_DROP)
      `CHK("max_len", lim(t), MAX_LEN)
      `CHK("frm_storm", (&da) || (da[40] && !c2_m[6]), FRM_STORM)
      `CHK("frm_pause_act", p && c1_m[4], FRM_PAUSE_ACT)
   endtask
   task automatic count_ticks(int n);
      ticks = 0;
      repeat (n) begin
         @(posedge CLK); #1;
         if (AGE_TICK === 1'b1) ticks++;
      end
   endtask
   task automatic do_reset();
      RST_N = 1'b0;
      repeat (2) @(posedge CLK);
      #1 RST_N = 1'b1;
      c1_m = 8'h34; c2_m = 8'hF0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog against a hung run
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
   // main sequence
   initial begin
      {REG_WR, REG_RD, FRM_VALID, FRM_TAGGED, FRM_PAUSE} = '0;
      {REG_ADDR, REG_WDATA, FRM_LEN, FRM_DATA_LEN, FRM_LENTYPE, FRM_DA, FRM_COLL_CNT} = '0;
      do_reset();
      rd_chk(8'h03, 8'h34);
      rd_chk(8'h04, 8'hF0);
      levels();
      frame(1'b0, 11'h640, 16'h0800, 11'h000, 48'h0, 1'b1, 5'h10);
      $display("test defaults done");
      rd_chk(8'h05, 8'h00);
      wr(8'h03, 8'hFF);
      rd_chk(8'h03, 8'h3F);
      repeat (150) begin
         wr(8'h03, 8'(rnd()));
         wr_rd(8'h04, 8'(rnd()));
         rd_chk(8'h03, c1_m);
         rd_chk(8'h04, c2_m);
         levels();
         r = rnd();
         frame(r[30], bnd[r[1:0]] + 11'(r[3:2]) - 11'h001,
               r[4] ? {5'h00, r[15:5]} : 16'h0800, r[16] ? r[15:5] : r[27:17],
               r[28] ? '1 : {16'(rnd()), rnd()}, r[29], 5'(rnd()));
      end
      $display("test registers and frames done");
      wr(8'h03, 8'h30);
      count_ticks(60);
      `CHK("ticks_off", 0, ticks)
      wr(8'h03, 8'h36);
      count_ticks(72);
      `CHK("ticks_fast", 4, ticks)
      wr(8'h03, 8'h30);
      wr(8'h03, 8'h34);
      count_ticks(100);
      `CHK("ticks_norm", 2, ticks)
      $display("test aging done");
      do_reset();
      rd_chk(8'h03, 8'h34);
      rd_chk(8'h04, 8'hF0);
      $display("test second reset done");
      report_and_stop();
   end
endmodule // tb_switch_global_policy_control
